/* File: hw/ptbw_map.vh */
// constants for the pci target burst write block
// assumes inclusion by the design file and by the pin checker
`ifndef PTBW_MAP_VH
`define PTBW_MAP_VH
// ----------------------------------------
// command and select timing
// ----------------------------------------
`define PTBW_CMD_MEM_WRITE   4'h7
`define PTBW_SPEED_FAST      1'h0
`define PTBW_SPEED_SLOW      1'h1
// ----------------------------------------
// base address windows (match on upper bits)
// ----------------------------------------
`define PTBW_BAR0_BASE       32'h1000_0000
`define PTBW_BAR0_MASK       32'hfff0_0000
`define PTBW_BAR1_BASE       32'h2000_0000
`define PTBW_BAR1_MASK       32'hfff0_0000
`define PTBW_NUM_BAR         2
// ----------------------------------------
// state codes and reset values
// ----------------------------------------
`define PTBW_ST_IDLE         3'h0
`define PTBW_ST_DECODE       3'h1
`define PTBW_ST_HIT          3'h2
`define PTBW_ST_DATA         3'h3
`define PTBW_ST_TURN         3'h4
`define PTBW_ST_DONE         3'h5
`define PTBW_ZERO32          32'h0000_0000
`define PTBW_ZERO_BAR        2'h0
`endif

/* File: hw/ptbw_target.v */
// pci target burst write path to a 32-bit local back end
// assumes pci pins enter here as separate in/out/enable signals
// Notes on behaviour
// R1 - master asserts frame, drives address and write command in address cycle
// R2 - master drives byte enables next cycle, then irdy and first data
// R3 - cycle after address: decode captured address, show it to back end
// R4 - on address match, raise matching hit select one cycle later
// R5 - slow select timing: assert devsel the clock after hit select
// R6 - back end asserts ready when it can take data two cycles later
// R7 - assert trdy three cycles after back end ready was asserted
// R8 - while ready held, keep trdy and present latest accepted word
// R9 - irdy and ready both last cycle: assert transfer strobe
// R10 - back end writes word and counts address only on strobe
// R11 - after a completed phase master drives next enables and data
// R12 - master marks last phase by dropping frame with irdy held
// R13 - after last phase master releases frame, ad, cbe and irdy
// R14 - after last completed phase deassert devsel and trdy
// R15 - idle after transaction: clear hit, drop strobe, release devsel, trdy
// R16 - ready absent last cycle: hold trdy off and no strobe
`timescale 1ns/1ps
`include "ptbw_map.vh"
module ptbw_target (
    // clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    // configuration
    input  wire        select_response_speed,
    // pci bus from master
    input  wire        frame_n,
    input  wire        irdy_n,
    input  wire [31:0] ad_in,
    input  wire [3:0]  cbe_n,
    // pci target response
    output reg         devsel_n_out,
    output reg         devsel_n_oe,
    output reg         trdy_n_out,
    output reg         trdy_n_oe,
    // local back end
    input  wire        backend_ready_n,
    output reg  [31:0] local_target_addr_out,
    output reg  [1:0]  bar_hit,
    output reg  [31:0] local_data_out,
    output reg  [3:0]  local_byte_en_n,
    output reg         word_transfer_strobe_n
);
// ----------------------------------------
// pin synchronisers, control lines
// ----------------------------------------
reg        frame_s1;
reg        frame_s2;
reg        irdy_s1;
reg        irdy_s2;
reg        rdy_s1;
reg        rdy_s2;
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        frame_s1 <= 1'b1;
        frame_s2 <= 1'b1;
        irdy_s1  <= 1'b1;
        irdy_s2  <= 1'b1;
        rdy_s1   <= 1'b1;
        rdy_s2   <= 1'b1;
    end else begin
        frame_s1 <= frame_n;
        frame_s2 <= frame_s1;
        irdy_s1  <= irdy_n;
        irdy_s2  <= irdy_s1;
        rdy_s1   <= backend_ready_n;
        rdy_s2   <= rdy_s1;
    end
end
// ----------------------------------------
// pin synchronisers, address and data lines
// ----------------------------------------
reg [31:0] ad_s1;
reg [31:0] ad_s2;
reg [3:0]  cbe_s1;
reg [3:0]  cbe_s2;
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        ad_s1  <= `PTBW_ZERO32;
        ad_s2  <= `PTBW_ZERO32;
        cbe_s1 <= 4'hf;
        cbe_s2 <= 4'hf;
    end else begin
        ad_s1  <= ad_in;
        ad_s2  <= ad_s1;
        cbe_s1 <= cbe_n;
        cbe_s2 <= cbe_s1;
    end
end
// ----------------------------------------
// target outputs delayed to pin sample time
// ----------------------------------------
// pins reach the logic two clocks late, so trdy and devsel
// are delayed alike before a data phase is judged complete
reg        trdy_d1;
reg        trdy_d2;
reg        devsel_d1;
reg        devsel_d2;
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        trdy_d1   <= 1'b1;
        trdy_d2   <= 1'b1;
        devsel_d1 <= 1'b1;
        devsel_d2 <= 1'b1;
    end else begin
        trdy_d1   <= trdy_n_out;
        trdy_d2   <= trdy_d1;
        devsel_d1 <= devsel_n_out;
        devsel_d2 <= devsel_d1;
    end
end
// ----------------------------------------
// address match per window
// ----------------------------------------
wire [31:0] bar_base [0:1];
wire [31:0] bar_mask [0:1];
assign bar_base[0] = `PTBW_BAR0_BASE;
assign bar_mask[0] = `PTBW_BAR0_MASK;
assign bar_base[1] = `PTBW_BAR1_BASE;
assign bar_mask[1] = `PTBW_BAR1_MASK;
wire [1:0] match;
genvar gi;
generate
    for (gi = 0; gi < `PTBW_NUM_BAR; gi = gi + 1) begin : g_bar
        assign match[gi] = ((local_target_addr_out & bar_mask[gi]) == bar_base[gi]);
    end
endgenerate
// ----------------------------------------
// sequencer states
// ----------------------------------------
localparam [2:0] ST_IDLE   = `PTBW_ST_IDLE;
localparam [2:0] ST_DECODE = `PTBW_ST_DECODE;
localparam [2:0] ST_HIT    = `PTBW_ST_HIT;
localparam [2:0] ST_DATA   = `PTBW_ST_DATA;
localparam [2:0] ST_TURN   = `PTBW_ST_TURN;
localparam [2:0] ST_DONE   = `PTBW_ST_DONE;
// ----------------------------------------
// transaction sequencer
// ----------------------------------------
reg  [2:0] state;
reg        cmd_write;
reg        last_seen;
wire       rdy_now    = ~rdy_s2;
wire       irdy_now   = ~irdy_s2;
wire       phase_done = irdy_now && !trdy_d2 && !devsel_d2;
wire       last_phase = phase_done && (frame_s2 || last_seen);
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        state                  <= ST_IDLE;
        cmd_write              <= 1'b0;
        last_seen              <= 1'b0;
        devsel_n_out           <= 1'b1;
        devsel_n_oe            <= 1'b0;
        trdy_n_out             <= 1'b1;
        trdy_n_oe              <= 1'b0;
        local_target_addr_out  <= `PTBW_ZERO32;
        bar_hit                <= `PTBW_ZERO_BAR;
        local_data_out         <= `PTBW_ZERO32;
        local_byte_en_n        <= 4'hf;
        word_transfer_strobe_n <= 1'b1;
    end else begin
        case (state)
            ST_IDLE: begin
                word_transfer_strobe_n <= 1'b1;
                devsel_n_oe            <= 1'b0;
                trdy_n_oe              <= 1'b0;
                last_seen              <= 1'b0;
                if (!frame_s2) begin
                    local_target_addr_out <= ad_s2;                     // [R3]
                    cmd_write <= (cbe_s2 == `PTBW_CMD_MEM_WRITE);
                    state     <= ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (cmd_write && (match != `PTBW_ZERO_BAR)) begin
                    bar_hit <= match;                                   // [R4]
                    state   <= ST_HIT;
                end else begin
                    state   <= ST_DONE;
                end
            end
            ST_HIT: begin
                devsel_n_out <= 1'b0;                                   // [R5]
                devsel_n_oe  <= 1'b1;
                trdy_n_oe    <= 1'b1;
                trdy_n_out   <= ~rdy_now;                               // [R7]
                state        <= ST_DATA;
            end
            ST_DATA: begin
                trdy_n_out <= ~rdy_now;                                 // [R8] [R16]
                if (phase_done) begin
                    local_data_out  <= ad_s2;                           // [R8]
                    local_byte_en_n <= cbe_s2;
                end
                word_transfer_strobe_n <= ~phase_done;                  // [R9] [R16]
                if (frame_s2 && irdy_now)
                    last_seen <= 1'b1;                                  // [R12]
                if (last_phase) begin
                    devsel_n_out <= 1'b1;                               // [R14]
                    trdy_n_out   <= 1'b1;
                    state        <= ST_TURN;
                end
            end
            ST_TURN: begin
                bar_hit                <= `PTBW_ZERO_BAR;               // [R15]
                word_transfer_strobe_n <= 1'b1;
                devsel_n_oe            <= 1'b0;
                trdy_n_oe              <= 1'b0;
                state                  <= ST_DONE;
            end
            ST_DONE: begin
                bar_hit <= `PTBW_ZERO_BAR;
                if (frame_s2 && !irdy_now)
                    state <= ST_IDLE;                                   // [R13]
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end
endmodule // ptbw_target

/* File: tb/ptbw_monitor.sv */
// checker on the target pins of the burst write block
// assumes binding onto ptbw_target
`timescale 1ns/1ps
`include "ptbw_map.vh"
module ptbw_monitor (
    input wire        sys_clk, resetn, backend_ready_n, word_transfer_strobe_n,
    input wire        devsel_n_out, devsel_n_oe, trdy_n_out, trdy_n_oe,
    input wire [1:0]  bar_hit,
    input wire [31:0] local_target_addr_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_idle_be; backend_ready_n [*4]; endsequence
    sequence s_long_idle_be; backend_ready_n [*8]; endsequence
    sequence s_hit_up; $rose(|bar_hit); endsequence
    property p_addr; s_hit_up |-> $stable(local_target_addr_out); endproperty
    property p_hit; s_hit_up |-> bar_hit == (((local_target_addr_out & `PTBW_BAR0_MASK)
        == `PTBW_BAR0_BASE) ? 2'h1 : 2'h2); endproperty
    property p_sel; s_hit_up |-> ##[1:2] (!devsel_n_out && devsel_n_oe); endproperty
    property p_end; $rose(devsel_n_out) |-> ##[1:2] (bar_hit == 2'h0 && !devsel_n_oe);
    endproperty
    property p_tsel; (trdy_n_oe && !trdy_n_out) |-> !devsel_n_out; endproperty
    property p_wait; s_idle_be |-> trdy_n_out; endproperty
    property p_nost; s_long_idle_be |-> word_transfer_strobe_n; endproperty
    property p_sthit; !word_transfer_strobe_n |-> bar_hit != 2'h0; endproperty
    a_addr: assert property (p_addr) else $error("address moved at hit");
    a_hit: assert property (p_hit) else $error("wrong hit select");
    a_sel: assert property (p_sel) else $error("select late");
    a_end: assert property (p_end) else $error("hit not cleared");
    a_tsel: assert property (p_tsel) else $error("trdy without devsel");
    a_wait: assert property (p_wait) else $error("trdy while not ready");
    a_nost: assert property (p_nost) else $error("strobe while not ready");
    a_sthit: assert property (p_sthit) else $error("strobe outside hit");
endmodule // ptbw_monitor
bind ptbw_target ptbw_monitor i_ptbw_monitor (
    .sys_clk(sys_clk), .resetn(resetn), .backend_ready_n(backend_ready_n),
    .word_transfer_strobe_n(word_transfer_strobe_n), .devsel_n_out(devsel_n_out),
    .devsel_n_oe(devsel_n_oe), .trdy_n_out(trdy_n_out), .trdy_n_oe(trdy_n_oe),
    .bar_hit(bar_hit), .local_target_addr_out(local_target_addr_out));

/* File: tb/ptbw_master.sv */
// pci master model issuing one burst write per go pulse
// assumes pulled-up devsel_n and trdy_n from the bench
`timescale 1ns/1ps
module ptbw_master (
    input  wire        sys_clk, go, devsel_n, trdy_n,
    input  wire [31:0] m_addr,
    input  wire [3:0]  m_cmd,
    input  wire [2:0]  m_n,
    output reg         frame_n, irdy_n, m_busy,
    output reg  [31:0] ad,
    output reg  [3:0]  cbe_n
);
    integer k, w;
    initial begin
        {frame_n, irdy_n, m_busy, ad, cbe_n} = {3'h6, 32'h0, 4'hf};
        forever begin
            @(posedge sys_clk);
            if (go) begin
                {m_busy, frame_n, ad, cbe_n} <= {2'h2, m_addr, m_cmd};
                @(posedge sys_clk);
                w = 0;
                irdy_n <= 1'b0;
                frame_n <= (m_n == 3'h1);
                {ad, cbe_n} <= {32'hc0de_0000, 4'h0};
                for (k = 0; w < m_n && k < 64; k = k + 1) begin
                    @(posedge sys_clk);
                    if (!irdy_n && !trdy_n && !devsel_n) begin
                        w = w + 1;
                        if (w < m_n) begin
                            {ad, cbe_n} <= {32'hc0de_0000 + w, w[3:0]};
                            frame_n <= (w + 1 >= m_n);
                        end
                    end
                end
                {frame_n, irdy_n, m_busy} <= 3'h6;
                {ad, cbe_n} <= ~{ad, cbe_n};
            end
        end
    end
endmodule // ptbw_master

/* File: tb/tb.sv */
// bench for the burst write target with master model and back end
// assumes ptbw_target, ptbw_master and the bound checker
`timescale 1ns/1ps
module tb;
    reg         sys_clk, resetn, backend_ready_n, go;
    reg  [31:0] m_addr;
    reg  [3:0]  m_cmd;
    reg  [2:0]  m_n;
    reg  [1:0]  hit_seen;
    wire        frame_n, irdy_n, m_busy, devsel_n_out, devsel_n_oe;
    wire        trdy_n_out, trdy_n_oe, word_transfer_strobe_n;
    wire [31:0] ad, local_target_addr_out, local_data_out;
    wire [3:0]  cbe_n, local_byte_en_n;
    wire [1:0]  bar_hit;
    wire        select_response_speed = 1'b1;
    wire        devsel_n = devsel_n_oe ? devsel_n_out : 1'b1;
    wire        trdy_n = trdy_n_oe ? trdy_n_out : 1'b1;
    integer     n_errors, check_count, n_got;
    ptbw_target i_ptbw_target (
        .sys_clk(sys_clk), .resetn(resetn), .select_response_speed(select_response_speed),
        .frame_n(frame_n), .irdy_n(irdy_n), .ad_in(ad), .cbe_n(cbe_n),
        .devsel_n_out(devsel_n_out), .devsel_n_oe(devsel_n_oe),
        .trdy_n_out(trdy_n_out), .trdy_n_oe(trdy_n_oe),
        .backend_ready_n(backend_ready_n), .local_target_addr_out(local_target_addr_out),
        .bar_hit(bar_hit), .local_data_out(local_data_out),
        .local_byte_en_n(local_byte_en_n), .word_transfer_strobe_n(word_transfer_strobe_n));
    ptbw_master i_ptbw_master (
        .sys_clk(sys_clk), .go(go), .devsel_n(devsel_n), .trdy_n(trdy_n),
        .m_addr(m_addr), .m_cmd(m_cmd), .m_n(m_n), .frame_n(frame_n), .irdy_n(irdy_n),
        .m_busy(m_busy), .ad(ad), .cbe_n(cbe_n));
    initial begin
        {sys_clk, resetn, backend_ready_n, go, m_addr, m_cmd, m_n, hit_seen} = 0;
        {n_errors, check_count, n_got} = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task chk32(input [31:0] act, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (act !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR %0t got %h want %h", $time, act, exp);
            end
        end
    endtask
    always @(posedge sys_clk) begin
        if (|bar_hit) hit_seen <= bar_hit;
        if (resetn && word_transfer_strobe_n === 1'b0) begin
            chk32(local_data_out, 32'hc0de_0000 + n_got);
            chk32({28'h0, local_byte_en_n}, n_got);
            n_got = n_got + 1;
        end
    end
    task xfer(input [31:0] a, input [3:0] c, input [2:0] n, input st, input [31:0] en, eh);
        integer t;
        begin
            n_got = 0;
            {hit_seen, m_addr, m_cmd, m_n, go} <= {2'h0, a, c, n, 1'b1};
            for (t = 0; t < 90 && (t < 3 || m_busy); t = t + 1) begin
                @(posedge sys_clk);
                go <= 1'b0;
                backend_ready_n <= st && t >= 3 && t < 12;
            end
            repeat (6) @(posedge sys_clk);
            chk32(local_target_addr_out, a);
            chk32(n_got, en);
            chk32(hit_seen, eh);
            chk32({bar_hit, devsel_n_oe, trdy_n_oe, word_transfer_strobe_n}, 32'h1);
        end
    endtask
    task t_burst;
        begin
            xfer(32'h1000_0040, 4'h7, 3'h3, 1'b0, 3, 1);
            xfer(32'h100f_fffc, 4'h7, 3'h1, 1'b0, 1, 1);
        end
    endtask
    task t_stall;
        xfer(32'h2000_0100, 4'h7, 3'h3, 1'b1, 3, 2);
    endtask
    task t_refuse;
        begin
            xfer(32'h1000_0000, 4'h6, 3'h2, 1'b0, 0, 0);
            xfer(32'h3000_0000, 4'h7, 3'h2, 1'b0, 0, 0);
        end
    endtask
    task stop_test;
        begin
            $display("errors %0d checks %0d", n_errors, check_count);
            if (n_errors == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_burst;
        t_stall;
        t_refuse;
        stop_test;
    end
    initial begin
        #40000;
        n_errors = n_errors + 1;
        stop_test;
    end
endmodule // tb
